// file: verilog/cpu_sideband_defs.svh
// Constants for the processor sideband control block.
// Assumes inclusion by bare name; definitions only.
`ifndef CPU_SIDEBAND_DEFS_SVH
`define CPU_SIDEBAND_DEFS_SVH
// Mode-select bit positions in the debug mode control word
`define DBG_BP0_BIT        0
`define DBG_BP1_BIT        1
// Reset value of the debug mode control word: both pins on monitor
`define DBG_CTRL_RESET     2'h0
// Strap codes taken from {flush, init} at reset release
`define STRAP_TRISTATE     2'h1
`define STRAP_CHECKER      2'h2
`define STRAP_SELFTEST     2'h3
// Lines to sweep in the cache invalidate
`define INVAL_LINES        256
// Stop grant acknowledge cycle length, in clocks
`define STOP_GRANT_CYCLES  4'h2
`endif

// file: verilog/cpu_sideband_pkg.sv
// Types shared by the sideband control block.
// Assumes the defs header is included where counts are needed.
package cpu_sideband_pkg;
   // Operating state of the core sequencing
   typedef enum logic [5:0] {
      ST_RESET  = 6'h01,
      ST_INVAL  = 6'h02,
      ST_RUN    = 6'h04,
      ST_SMM    = 6'h08,
      ST_GRANT  = 6'h10,
      ST_STOP   = 6'h20
   } core_state_e;
   // Power-up test mode chosen from straps
   typedef enum logic [1:0] {
      MODE_NORMAL   = 2'h0,
      MODE_TRISTATE = 2'h1,
      MODE_CHECKER  = 2'h2,
      MODE_SELFTEST = 2'h3
   } test_mode_e;
endpackage : cpu_sideband_pkg

// file: verilog/bp_pin_mux.sv
// Per-pin selection of breakpoint or performance-monitor output.
// Assumes select bits come from a register of the parent.
`timescale 1ns/100ps
module bp_pin_mux #(
   parameter int N = 2            // Number of multiplexed pins
) (
   // Clock and reset
   input  wire logic         i_ref_clk,
   input  wire logic         i_rst_b,
   // Select and sources
   input  wire logic [N-1:0] i_sel_bp,
   input  wire logic [N-1:0] i_breakpoint,
   input  wire logic [N-1:0] i_perfmon,
   // Pins
   output logic      [N-1:0] o_pins
);
   genvar g;
   // One registered pin per channel; high select picks breakpoint
   generate
      for (g = 0; g < N; g++) begin : g_pin
         always_ff @(posedge i_ref_clk) begin
            if (!i_rst_b) begin
               o_pins[g] <= 1'b0;
            end else if (i_sel_bp[g]) begin
               o_pins[g] <= i_breakpoint[g];
            end else begin
               o_pins[g] <= i_perfmon[g];
            end
         end
      end
   endgenerate
endmodule : bp_pin_mux

// file: verilog/cpu_sideband_control.sv
// Processor sideband control: reset sequencing, straps, system
// management mode, stop clock, pin muxing and cycle indications.
// Assumes the chipset drives inputs synchronous to i_ref_clk and
// that core logic reports instruction boundaries and bus events.
`timescale 1ns/100ps
`include "cpu_sideband_defs.svh"
module cpu_sideband_control #(
   parameter int INVAL_LINES = `INVAL_LINES // Invalidate sweep length
) (
   // Clock and reset
   input  wire logic                          i_ref_clk,
   input  wire logic                          i_rst_b,
   // Straps sampled at reset release
   input  wire logic                          i_flush_n,
   input  wire logic                          i_init,
   // Chipset requests
   input  wire logic                          i_sys_mgmt_irq_n,
   input  wire logic                          i_stop_clock_req_n,
   input  wire logic                          i_snoop_req,
   input  wire logic                          i_ipi_req,
   // Core status
   input  wire logic                          i_insn_boundary,
   input  wire logic                          i_high_pri_irq,
   input  wire logic                          i_smm_resume,
   // Debug control word write
   input  wire logic                          i_dbg_ctrl_we,
   input  wire logic [1:0]                    i_dbg_ctrl_wdata,
   // Pin sources
   input  wire logic [1:0]                    i_breakpoint,
   input  wire logic [1:0]                    i_perfmon,
   // Paging and lock attributes of current cycle
   input  wire logic                          i_pwt_dir_base,
   input  wire logic                          i_pwt_dir_entry,
   input  wire logic                          i_pwt_table_entry,
   input  wire logic [1:0]                    i_pwt_src,
   input  wire logic                          i_locked,
   input  wire logic                          i_misaligned,
   // Status and pins
   output cpu_sideband_pkg::core_state_e      o_state,
   output cpu_sideband_pkg::test_mode_e       o_test_mode,
   output logic                               o_cache_inval,
   output logic                               o_cache_writeback,
   output logic                               o_sys_mgmt_active_n,
   output logic                               o_stop_grant_cycle,
   output logic                               o_core_clk_en,
   output logic                               o_snoop_ack,
   output logic                               o_ipi_ack,
   output logic [1:0]                         o_bp_pins,
   output logic [1:0]                         o_dbg_ctrl,
   output logic                               o_page_write_through,
   output logic                               o_split_cycle
);
   import cpu_sideband_pkg::*;

   localparam int CW = $clog2(INVAL_LINES + 1);  // Sweep counter width

   core_state_e  state;           // Current sequencing state
   core_state_e  next_state;      // Next sequencing state
   logic [CW-1:0] inval_cnt;      // Lines left to invalidate
   logic [3:0]   grant_cnt;       // Stop grant cycle clocks left
   logic         rst_seen;        // Reset was held last cycle
   logic         smi_pend;        // Latched management request
   logic         stop_req;        // Stop request asserted

   assign stop_req = !i_stop_clock_req_n;

   // Remember reset so the release edge can catch straps
   always_ff @(posedge i_ref_clk) begin
      rst_seen <= !i_rst_b;
   end

   // Straps captured on the first clock after release, not under reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_test_mode <= MODE_NORMAL;
      end else if (rst_seen) begin
         case ({!i_flush_n, i_init})
            `STRAP_TRISTATE: o_test_mode <= MODE_TRISTATE;
            `STRAP_CHECKER:  o_test_mode <= MODE_CHECKER;
            `STRAP_SELFTEST: o_test_mode <= MODE_SELFTEST;
            default:         o_test_mode <= MODE_NORMAL;
         endcase
      end
   end

   // Request latch: a new assertion wins over the entry clear
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         smi_pend <= 1'b0;
      end else if (!i_sys_mgmt_irq_n) begin
         smi_pend <= 1'b1;
      end else if (state == ST_RUN && i_insn_boundary) begin
         smi_pend <= 1'b0;
      end
   end

   // Next state; management request outranks stop clock
   always_comb begin
      next_state = state;
      case (state)
         ST_RESET: begin
            next_state = ST_INVAL;
         end
         ST_INVAL: begin
            if (inval_cnt == '0) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (i_insn_boundary && smi_pend) begin
               next_state = ST_SMM;
            end else if (i_insn_boundary && stop_req && !i_high_pri_irq) begin
               next_state = ST_GRANT;
            end
         end
         ST_SMM: begin
            if (i_smm_resume) begin
               next_state = ST_RUN;
            end
         end
         ST_GRANT: begin
            if (grant_cnt == 4'h1) begin
               next_state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (!stop_req) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RESET;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         state <= ST_RESET;
      end else begin
         state <= next_state;
      end
   end

   // Invalidate sweep counter, loaded on reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         inval_cnt <= CW'(INVAL_LINES);
      end else if (state == ST_INVAL && inval_cnt != '0) begin
         inval_cnt <= inval_cnt - CW'(1);
      end
   end

   // Grant cycle counter, loaded when the stop is taken
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         grant_cnt <= 4'h0;
      end else if (next_state == ST_GRANT && state != ST_GRANT) begin
         grant_cnt <= `STOP_GRANT_CYCLES;
      end else if (grant_cnt != 4'h0) begin
         grant_cnt <= grant_cnt - 4'h1;
      end
   end

   // Registered status outputs
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_cache_inval      <= 1'b0;
         o_sys_mgmt_active_n <= 1'b1;
         o_stop_grant_cycle <= 1'b0;
         o_core_clk_en      <= 1'b0;
      end else begin
         o_cache_inval      <= (next_state == ST_INVAL);
         o_sys_mgmt_active_n <= !(next_state == ST_SMM);
         o_stop_grant_cycle <= (next_state == ST_GRANT);
         o_core_clk_en      <= (next_state == ST_RUN) || (next_state == ST_SMM);
      end
   end

   // Invalidation never writes modified lines back
   assign o_cache_writeback = 1'b0;
   assign o_state           = state;

   // Snoop and interprocessor service stay live in every state
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_snoop_ack <= 1'b0;
         o_ipi_ack   <= 1'b0;
      end else begin
         o_snoop_ack <= i_snoop_req;
         o_ipi_ack   <= i_ipi_req;
      end
   end

   // Debug mode control word; reset puts both pins on monitor
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_dbg_ctrl <= `DBG_CTRL_RESET;
      end else if (i_dbg_ctrl_we) begin
         o_dbg_ctrl <= i_dbg_ctrl_wdata;
      end
   end

   // Pin multiplexer
   bp_pin_mux #(
      .N            (2)
   ) u_bp_mux (
      .i_ref_clk    (i_ref_clk),
      .i_rst_b      (i_rst_b),
      .i_sel_bp     (o_dbg_ctrl),
      .i_breakpoint (i_breakpoint),
      .i_perfmon    (i_perfmon),
      .o_pins       (o_bp_pins)
   );

   // Write-through indication from the selected paging level
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_page_write_through <= 1'b0;
      end else begin
         case (i_pwt_src)
            2'h0:    o_page_write_through <= i_pwt_dir_base;
            2'h1:    o_page_write_through <= i_pwt_dir_entry;
            default: o_page_write_through <= i_pwt_table_entry;
         endcase
      end
   end

   // Split cycle; driven low on unlocked cycles where value is free
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_split_cycle <= 1'b0;
      end else begin
         o_split_cycle <= i_locked && i_misaligned;
      end
   end
endmodule : cpu_sideband_control

// file: tb/cpu_sideband_control_props.sv
// Checker for the sideband control block.
// Assumes binding to the top module; watches its ports only.
`timescale 1ns/100ps
module cpu_sideband_control_props (
   input wire logic                     i_ref_clk,
   input wire logic                     i_rst_b,
   input wire logic                     i_flush_n,
   input wire logic                     i_init,
   input wire logic                     i_snoop_req,
   input wire logic                     i_smm_resume,
   input wire logic [1:0]               i_pwt_src,
   input wire logic                     i_pwt_dir_base,
   input wire logic                     i_locked,
   input wire logic                     i_misaligned,
   input wire cpu_sideband_pkg::core_state_e o_state,
   input wire cpu_sideband_pkg::test_mode_e  o_test_mode,
   input wire logic                     o_cache_inval,
   input wire logic                     o_cache_writeback,
   input wire logic                     o_sys_mgmt_active_n,
   input wire logic                     o_stop_grant_cycle,
   input wire logic                     o_core_clk_en,
   input wire logic                     o_snoop_ack,
   input wire logic                     o_page_write_through,
   input wire logic                     o_split_cycle
);
   import cpu_sideband_pkg::*;
   // One clock domain, so one default clock and disable
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   a_strap_sample: assert property ($rose(i_rst_b) |=> o_test_mode == $past({!i_flush_n, i_init}))
      else $error("test mode not taken from straps");
   a_inval_start: assert property ($rose(i_rst_b) |=> o_cache_inval && !o_cache_writeback)
      else $error("invalidate did not start cleanly");
   a_smm_active: assert property (o_state == ST_SMM |-> !o_sys_mgmt_active_n)
      else $error("active flag high in management mode");
   a_smm_release: assert property (o_state == ST_SMM && i_smm_resume |=> o_sys_mgmt_active_n)
      else $error("active flag held after resume");
   a_grant_len: assert property ($rose(o_stop_grant_cycle) |-> o_stop_grant_cycle[*2] ##1 o_state == ST_STOP)
      else $error("grant cycle length wrong");
   a_stop_clk: assert property (o_stop_grant_cycle |-> !o_core_clk_en)
      else $error("core clock runs during grant");
   a_snoop_ack: assert property (i_snoop_req |=> o_snoop_ack)
      else $error("snoop not acknowledged");
   a_split_lock: assert property (i_locked && i_misaligned |=> o_split_cycle)
      else $error("split cycle missing");
   a_pwt_base: assert property (i_pwt_src == 2'h0 |=> o_page_write_through == $past(i_pwt_dir_base))
      else $error("write-through not from base");
endmodule : cpu_sideband_control_props
bind cpu_sideband_control cpu_sideband_control_props u_props (.i_ref_clk, .i_rst_b, .i_flush_n, .i_init,
   .i_snoop_req, .i_smm_resume, .i_pwt_src, .i_pwt_dir_base, .i_locked, .i_misaligned, .o_state,
   .o_test_mode, .o_cache_inval, .o_cache_writeback, .o_sys_mgmt_active_n, .o_stop_grant_cycle,
   .o_core_clk_en, .o_snoop_ack, .o_page_write_through, .o_split_cycle);

// file: tb/chipset_model.sv
// Chipset model driving request pins toward the processor.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/100ps
module chipset_model (
   // Clock
   input  wire logic i_ref_clk,
   // Request pins, active low ones idle high
   output logic      o_sys_mgmt_irq_n,
   output logic      o_stop_clock_req_n,
   output logic      o_snoop_req,
   output logic      o_ipi_req
);
   initial begin
      o_sys_mgmt_irq_n   = 1'b1;
      o_stop_clock_req_n = 1'b1;
      o_snoop_req        = 1'b0;
      o_ipi_req          = 1'b0;
   end
   // One-clock low pulse; the processor must latch it
   task automatic mgmt_irq();
      o_sys_mgmt_irq_n = 1'b0;
      @(posedge i_ref_clk) #1;
      o_sys_mgmt_irq_n = 1'b1;
   endtask : mgmt_irq
   // Level request held until released
   task automatic stop_req(input logic on);
      o_stop_clock_req_n = !on;
   endtask : stop_req
   // One-clock snoop and interprocessor pulses
   task automatic snoop(input logic s, input logic p);
      o_snoop_req = s;
      o_ipi_req   = p;
      @(posedge i_ref_clk) #1;
      o_snoop_req = 1'b0;
      o_ipi_req   = 1'b0;
   endtask : snoop
endmodule : chipset_model

// file: tb/cpu_sideband_control_bench.sv
// Self-checking bench for the sideband control block.
// Assumes a short invalidate sweep set by parameter.
`timescale 1ns/100ps
module cpu_sideband_control_bench;
   import cpu_sideband_pkg::*;
   logic clk = 0, rst_b = 0, flush_n = 1, init = 0, irq_n, stop_n, snp, ipi;
   logic bnd = 0, hpi = 0, rsm = 0, we = 0, pb = 0, pd = 0, pt = 0, lk = 0, mis = 0;
   logic [1:0] wd = 0, bp = 2'h2, pm = 2'h1, src = 0, pins, dbg;
   core_state_e st;
   test_mode_e  tm;
   logic inv, wb, act_n, gnt, cken, sack, iack, page_write_through, split_cycle;
   int error_cnt = 0, checks_done = 0;
   cpu_sideband_control #(.INVAL_LINES(4)) uut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_flush_n(flush_n),
      .i_init(init), .i_sys_mgmt_irq_n(irq_n), .i_stop_clock_req_n(stop_n), .i_snoop_req(snp),
      .i_ipi_req(ipi), .i_insn_boundary(bnd), .i_high_pri_irq(hpi), .i_smm_resume(rsm),
      .i_dbg_ctrl_we(we), .i_dbg_ctrl_wdata(wd), .i_breakpoint(bp), .i_perfmon(pm),
      .i_pwt_dir_base(pb), .i_pwt_dir_entry(pd), .i_pwt_table_entry(pt), .i_pwt_src(src),
      .i_locked(lk), .i_misaligned(mis), .o_state(st), .o_test_mode(tm), .o_cache_inval(inv),
      .o_cache_writeback(wb), .o_sys_mgmt_active_n(act_n), .o_stop_grant_cycle(gnt),
      .o_core_clk_en(cken), .o_snoop_ack(sack), .o_ipi_ack(iack), .o_bp_pins(pins),
      .o_dbg_ctrl(dbg), .o_page_write_through(page_write_through), .o_split_cycle(split_cycle));
   chipset_model chip (.i_ref_clk(clk), .o_sys_mgmt_irq_n(irq_n), .o_stop_clock_req_n(stop_n),
      .o_snoop_req(snp), .o_ipi_req(ipi));
   initial begin
      forever #5 clk = !clk;
   end
   // Inputs move 1 ns after the rising edge
   task automatic step(input int n = 1);
      repeat (n) @(posedge clk) #1;
   endtask : step
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse_bnd();
      bnd = 1;
      step();
      bnd = 0;
   endtask : pulse_bnd
   // One strap code per call, then wait for the run state
   task automatic test_reset(input logic [1:0] s);
      int n;
      rst_b   = 0;
      flush_n = !s[1];
      init    = s[0];
      step(4);
      rst_b = 1;
      step();
      chk(tm, s);
      chk(st, ST_INVAL);
      chk({inv, wb}, 8'h2);
      chk(dbg, 8'h0);
      chk(pins, pm);
      for (n = 0; n < 20 && st !== ST_RUN; n++) step();
      chk(st, ST_RUN);
   endtask : test_reset
   // Management entry, stop ignored meanwhile, then exit
   task automatic test_smm();
      chip.mgmt_irq();
      step(2);
      chk(st, ST_RUN);
      pulse_bnd();
      chk({st, act_n}, {ST_SMM, 1'b0});
      chip.stop_req(1);
      pulse_bnd();
      chk(st, ST_SMM);
      rsm = 1;
      step();
      rsm = 0;
      chk({st, act_n}, {ST_RUN, 1'b1});
   endtask : test_smm
   // Stop blocked, then granted, snoop served in grant, interprocessor while stopped
   task automatic test_stop();
      hpi = 1;
      pulse_bnd();
      chk(st, ST_RUN);
      hpi = 0;
      pulse_bnd();
      chk({st, gnt, cken}, {ST_GRANT, 2'h2});
      chip.snoop(1, 0);
      chk({sack, gnt}, 8'h3);
      step();
      chk({st, gnt}, {ST_STOP, 1'b0});
      chip.snoop(0, 1);
      chk(iack, 1);
      chip.stop_req(0);
      step();
      chk({st, cken}, {ST_RUN, 1'b1});
   endtask : test_stop
   // All four select codes on the shared pins
   task automatic test_pins();
      for (int s = 0; s < 4; s++) begin
         we = 1;
         wd = s[1:0];
         step();
         we = 0;
         step(2);
         chk(dbg, s);
         chk(pins, (wd & bp) | (~wd & pm));
      end
   endtask : test_pins
   // Attribute sources and locked split cycles
   task automatic test_attr();
      {pb, pd, pt} = 3'h5;
      for (int s = 0; s < 4; s++) begin
         src = s[1:0];
         step(2);
         chk(page_write_through, s == 1 ? 0 : 1);
      end
      {lk, mis} = 2'h3;
      step();
      chk(split_cycle, 1);
      lk = 0;
      step();
      chk(split_cycle, 0);
   endtask : test_attr
   task automatic report_and_stop();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      #20000;
      error_cnt++;
      report_and_stop();
   end
   // Reset already low from time zero; the first sweep holds it four edges
   initial begin
      for (int s = 0; s < 4; s++) test_reset(s[1:0]);
      test_smm();
      test_stop();
      test_pins();
      test_attr();
      report_and_stop();
   end
endmodule : cpu_sideband_control_bench
